// ===== shared/i2m_pkg.sv
// shared constants, register map and state types of the two-wire master time-out block
package i2m_pkg;

    // register byte offsets
    localparam logic [5:0] OFS_CTRL_A      = 6'h00;
    localparam logic [5:0] OFS_CTRL_B      = 6'h04;
    localparam logic [5:0] OFS_BIT_RATE    = 6'h0C;
    localparam logic [5:0] OFS_IRQ_EN_CLR  = 6'h14;
    localparam logic [5:0] OFS_IRQ_EN_SET  = 6'h16;
    localparam logic [5:0] OFS_IRQ_FLAGS   = 6'h18;
    localparam logic [5:0] OFS_BUS_STATUS  = 6'h1A;
    localparam logic [5:0] OFS_SYNC_PEND   = 6'h1C;
    localparam logic [5:0] OFS_TARGET_ADDR = 6'h24;
    localparam logic [5:0] OFS_XFER_BYTE   = 6'h28;
    localparam logic [5:0] OFS_DEBUG_CTRL  = 6'h30;

    // access sizes
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_HALF = 2'h1;
    localparam logic [1:0] SZ_WORD = 2'h2;

    // field positions
    localparam int CA_SWRST      = 0;
    localparam int CA_ENABLE     = 1;
    localparam int CA_IDLE_TO    = 28;
    localparam int CA_LOW_TO_EN  = 30;
    localparam int CB_CMD        = 16;
    localparam int FL_MASTER_BUS = 0;
    localparam int FL_SLAVE_BUS  = 1;
    localparam int FL_ERROR      = 7;
    localparam int ST_BUS_FAULT  = 0;
    localparam int ST_BUS_STATE  = 4;
    localparam int ST_LOW_TO     = 6;
    localparam int ST_CLK_HOLD   = 7;

    // writable masks and stop command code
    localparam logic [31:0] CA_WMASK     = 32'h7BF1009C;
    localparam logic [31:0] CB_WMASK     = 32'h00000300;
    localparam logic [31:0] CB_ACK_MASK  = 32'h00040000;
    localparam logic [31:0] TA_WMASK     = 32'h00FFE7FF;
    localparam logic [7:0]  IRQ_MASK     = 8'h83;
    localparam logic [15:0] ST_W1C_MASK  = 16'h0747;
    localparam logic [7:0]  DBG_WMASK    = 8'h01;
    localparam logic [1:0]  CMD_STOP     = 2'h3;

    // bus state field encoding
    localparam logic [1:0] BS_IDLE  = 2'h1;
    localparam logic [1:0] BS_OWNER = 2'h2;
    localparam logic [1:0] BS_BUSY  = 2'h3;

    // timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int LOW_TO_MIN_MS = 25;
    localparam int LOW_TO_CYC    = (LOW_TO_MIN_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BUS_RATE_KHZ  = 100;
    localparam int SCL_PERIOD_NS = 1000000 / BUS_RATE_KHZ;
    localparam int IDLE_TO1_SCL  = 5;
    localparam int IDLE_TO2_SCL  = 10;
    localparam int IDLE_TO3_SCL  = 20;
    localparam int IDLE_TO1_CYC  = IDLE_TO1_SCL * SCL_PERIOD_NS / CLK_PERIOD_NS;
    localparam int IDLE_TO2_CYC  = IDLE_TO2_SCL * SCL_PERIOD_NS / CLK_PERIOD_NS;
    localparam int IDLE_TO3_CYC  = IDLE_TO3_SCL * SCL_PERIOD_NS / CLK_PERIOD_NS;
    localparam int STOP_HALF_CYC = SCL_PERIOD_NS / 2 / CLK_PERIOD_NS;
    localparam int SYNC_CYC      = 3;
    localparam int LOW_CNT_W     = 20;
    localparam int IDLE_CNT_W    = 13;
    localparam int STOP_CNT_W    = 8;

    typedef enum logic [1:0] {STP_IDLE, STP_SETUP, STP_SCL_UP, STP_SDA_UP} i2m_stop_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [5:0]  addr;
        logic [1:0]  size;
        logic [31:0] wdata;
    } i2m_req_t;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic f;
    } i2m_pin_t;

    typedef struct packed {
        logic [31:0]           ctrl_a;
        logic [31:0]           ctrl_b;
        logic [31:0]           bit_rate;
        logic [7:0]            irq_en;
        logic [7:0]            flags;
        logic [15:0]           status;
        logic [7:0]            xfer_byte;
        logic [31:0]           tgt_addr;
        logic [7:0]            dbg;
        logic                  sync_swrst;
        logic                  sync_en;
        logic [1:0]            sync_cnt;
        logic                  en_core;
        i2m_pin_t              scl;
        i2m_pin_t              sda;
        logic [LOW_CNT_W-1:0]  low_cnt;
        logic [IDLE_CNT_W-1:0] idle_cnt;
        i2m_stop_t             stp;
        logic [STOP_CNT_W-1:0] stp_cnt;
        logic                  last_rd;
        logic [31:0]           rdata;
        logic                  err;
    } i2m_state_t;

endpackage

// ===== rtl/i2m_master_timeout.sv
// register file and bus time-out control of the two-wire master
`timescale 1ns/1ps

// Behaviour
// - registers are 8, 16 or 32 bits; 8/16/32-bit accesses are atomic
// - each byte and halfword of a register is addressable on its own
// - guarded registers ignore writes while the access guard is locked
// - marked registers pass through a synchronizer before taking effect
// - enable-protected registers take writes only while the peripheral is disabled
// - control_a bit 30 enables the SCL low time-out
// - SCL low 25-35 ms: release own clock hold and finish the transaction
// - after an SCL low time-out a stop condition is sent automatically
// - on low time-out master/slave bus flag sets as usual, clock hold released
// - on low time-out set low time-out and bus fault status bits
// - idle time-out field 29:28 forces bus state idle after inactive period
// - bus counts as inactive while SCL is held low by anyone
// - idle time-out periods assume a 100 kHz bus rate
// - low time-out enable and idle time-out field act without sync delay
// - idle field: 0 off, 1 about 5-6, 2 about 10-11, 3 about 20-21 SCL cycles
module i2m_master_timeout import i2m_pkg::*; #(
    parameter int LOW_TO_CYCLES   = LOW_TO_CYC,   // scl low time-out in cycles
    parameter int IDLE_TO3_CYCLES = IDLE_TO3_CYC  // longest idle time-out in cycles
) (
    input  wire logic        clk_sys,     // core clock
    input  wire logic        rst_b,       // synchronous reset, active low
    input  wire i2m_req_t    req,         // register access request
    input  wire logic        guard_lock,  // access guard locks this peripheral
    input  wire logic        xfer_done,   // byte engine finished a byte
    input  wire logic        xfer_read,   // that byte was a read
    output logic [31:0]      rdata,       // read data, one cycle after rd
    output logic             err,         // refused or unmapped access
    input  wire logic        scl_i,       // scl pin level
    output logic             scl_o,       // scl output level
    output logic             scl_drv_b,   // low while scl is pulled low
    input  wire logic        sda_i,       // sda pin level
    output logic             sda_o,       // sda output level
    output logic             sda_drv_b    // low while sda is pulled low
);

    localparam logic [3:0] W_CA  = OFS_CTRL_A[5:2];
    localparam logic [3:0] W_CB  = OFS_CTRL_B[5:2];
    localparam logic [3:0] W_BR  = OFS_BIT_RATE[5:2];
    localparam logic [3:0] W_IE  = OFS_IRQ_EN_CLR[5:2];
    localparam logic [3:0] W_FL  = OFS_IRQ_FLAGS[5:2];
    localparam logic [3:0] W_SP  = OFS_SYNC_PEND[5:2];
    localparam logic [3:0] W_TA  = OFS_TARGET_ADDR[5:2];
    localparam logic [3:0] W_XB  = OFS_XFER_BYTE[5:2];
    localparam logic [3:0] W_DBG = OFS_DEBUG_CTRL[5:2];
    localparam logic [LOW_CNT_W-1:0] LOW_LIM = LOW_CNT_W'(LOW_TO_CYCLES);

    i2m_state_t            s;
    i2m_state_t            next_s;
    logic [4:0]            sh;
    logic                  aligned;
    logic [3:0]            be;
    logic [31:0]           m;
    logic [31:0]           wd;
    logic [3:0]            word;
    logic                  mapped;
    logic [31:0]           rv;
    logic [31:0]           sz_mask;
    logic                  guarded;
    logic                  en_prot;
    logic                  scl_hi;
    logic                  sda_agree;
    logic                  start_det;
    logic                  stop_det;
    logic                  low_evt;
    logic                  idle_evt;
    logic [IDLE_CNT_W-1:0] idle_lim;

    // three-stage pin filter: the level moves once stages two and three agree
    function automatic i2m_pin_t pin_step(input i2m_pin_t p, input logic d);
        i2m_pin_t r;
        r    = p;
        r.s1 = d;
        r.s2 = p.s1;
        r.s3 = p.s2;
        r.f  = (p.s2 == p.s3) ? p.s3 : p.f;
        return r;
    endfunction

    // byte lanes from size and low address bits; misaligned accesses get no lanes
    assign sh      = {req.addr[1:0], 3'b000};
    assign aligned = (req.size == SZ_BYTE) || (req.size == SZ_HALF && !req.addr[0])
                     || (req.size == SZ_WORD && req.addr[1:0] == 2'h0);
    assign be      = !aligned ? 4'h0 :
                     4'((req.size == SZ_BYTE ? 4'h1 : req.size == SZ_HALF ? 4'h3 : 4'hF)
                        << req.addr[1:0]);
    assign sz_mask = req.size == SZ_BYTE ? 32'h000000FF :
                     req.size == SZ_HALF ? 32'h0000FFFF : 32'hFFFFFFFF;
    assign wd      = req.wdata << sh;
    assign word    = req.addr[5:2];

    for (genvar i = 0; i < 4; i++) begin : g_lane
        assign m[8*i +: 8] = {8{be[i]}};
    end

    assign guarded = (word == W_CA) || (word == W_CB) || (word == W_BR) || (word == W_IE)
                     || (word == W_TA) || (word == W_DBG);
    assign en_prot = s.ctrl_a[CA_ENABLE] | s.en_core;

    always_comb begin
        mapped = 1'b1;
        case (word)
            W_CA:    rv = s.ctrl_a;
            W_CB:    rv = s.ctrl_b;
            W_BR:    rv = s.bit_rate;
            W_IE:    rv = {8'h00, s.irq_en, 8'h00, s.irq_en};
            W_FL:    rv = {s.status, 8'h00, s.flags};
            W_SP:    rv = {30'h0, s.sync_en, s.sync_swrst};
            W_TA:    rv = s.tgt_addr;
            W_XB:    rv = {24'h0, s.xfer_byte};
            W_DBG:   rv = {24'h0, s.dbg};
            default: begin
                mapped = 1'b0;
                rv     = 32'h0;
            end
        endcase
        // during a software reset registers read as reset, only the reset flags show it
        if (s.sync_swrst && word != W_DBG && word != W_SP) begin
            rv = (word == W_CA) ? (32'h1 << CA_SWRST) : 32'h0;
        end
    end

    always_comb begin
        case (s.ctrl_a[CA_IDLE_TO +: 2])
            2'h1:    idle_lim = IDLE_CNT_W'(IDLE_TO1_CYC);
            2'h2:    idle_lim = IDLE_CNT_W'(IDLE_TO2_CYC);
            default: idle_lim = IDLE_CNT_W'(IDLE_TO3_CYCLES);
        endcase
    end

    // enable and field are read straight from control_a, not from the synced copy
    assign scl_hi    = s.scl.f;
    assign sda_agree = (s.sda.s2 == s.sda.s3) && (s.sda.s3 != s.sda.f);
    assign start_det = scl_hi && sda_agree && !s.sda.s3;
    assign stop_det  = scl_hi && sda_agree && s.sda.s3;
    assign low_evt   = s.en_core && s.ctrl_a[CA_LOW_TO_EN] && !scl_hi
                       && s.low_cnt == LOW_LIM - 1'b1;
    assign idle_evt  = s.en_core && s.ctrl_a[CA_IDLE_TO +: 2] != 2'h0 && !scl_hi
                       && s.idle_cnt == idle_lim - 1'b1;

    always_comb begin
        next_s     = s;
        next_s.err = 1'b0;
        next_s.scl = pin_step(s.scl, scl_i);
        next_s.sda = pin_step(s.sda, sda_i);

        // enable and reset requests settle after a fixed sync delay
        if (s.sync_en || s.sync_swrst) begin
            next_s.sync_cnt = s.sync_cnt + 2'h1;
            if (s.sync_cnt == 2'(SYNC_CYC - 1)) begin
                next_s.sync_cnt = 2'h0;
                next_s.sync_en  = 1'b0;
                next_s.en_core  = s.ctrl_a[CA_ENABLE];
            end
        end

        // register writes come first so that hardware sets below win over clears
        if (req.wr) begin
            if (!aligned || !mapped || s.sync_swrst || (guarded && guard_lock)) begin
                next_s.err = 1'b1;
            end else begin
                case (word)
                    W_CA: begin
                        if (m[CA_SWRST] && wd[CA_SWRST]) begin
                            // reset wins: the rest of this write is dropped
                            next_s.ctrl_a[CA_SWRST] = 1'b1;
                            next_s.sync_swrst       = 1'b1;
                            next_s.sync_cnt         = 2'h0;
                        end else begin
                            if (m[CA_ENABLE]) begin
                                next_s.ctrl_a[CA_ENABLE] = wd[CA_ENABLE];
                                next_s.sync_en           = 1'b1;
                                next_s.sync_cnt          = 2'h0;
                            end
                            if (!en_prot) begin
                                next_s.ctrl_a = (next_s.ctrl_a & ~(m & CA_WMASK))
                                                | (wd & m & CA_WMASK);
                            end
                        end
                    end
                    W_CB: begin
                        next_s.ctrl_b = (s.ctrl_b & ~(m & CB_ACK_MASK)) | (wd & m & CB_ACK_MASK);
                        if (!en_prot) begin
                            next_s.ctrl_b = (next_s.ctrl_b & ~(m & CB_WMASK))
                                            | (wd & m & CB_WMASK);
                        end
                        if (m[CB_CMD] && wd[CB_CMD +: 2] == CMD_STOP && s.en_core) begin
                            next_s.status[ST_CLK_HOLD] = 1'b0;
                            next_s.stp                 = STP_SETUP;
                            next_s.stp_cnt             = '0;
                        end
                    end
                    W_BR: begin
                        if (!en_prot) begin
                            next_s.bit_rate = (s.bit_rate & ~m) | (wd & m);
                        end
                    end
                    W_IE: begin
                        next_s.irq_en = (s.irq_en & ~(wd[7:0] & m[7:0] & IRQ_MASK))
                                        | (wd[23:16] & m[23:16] & IRQ_MASK);
                    end
                    W_FL: begin
                        next_s.flags  = s.flags & ~(wd[7:0] & m[7:0] & IRQ_MASK);
                        next_s.status = s.status & ~(wd[31:16] & m[31:16] & ST_W1C_MASK);
                    end
                    W_TA: next_s.tgt_addr = (s.tgt_addr & ~(m & TA_WMASK)) | (wd & m & TA_WMASK);
                    W_XB: begin
                        if (m[0]) begin
                            next_s.xfer_byte = wd[7:0];
                        end
                    end
                    W_DBG: next_s.dbg = (s.dbg & ~(m[7:0] & DBG_WMASK)) | (wd[7:0] & m[7:0] & DBG_WMASK);
                    default: ;
                endcase
            end
        end
        if (req.rd) begin
            next_s.rdata = (aligned && mapped) ? ((rv >> sh) & sz_mask) : 32'h0;
            next_s.err   = !(aligned && mapped);
        end
        // touching the data byte hands the bus back to the byte engine
        if ((req.wr || req.rd) && aligned && word == W_XB && !s.sync_swrst) begin
            next_s.status[ST_CLK_HOLD]  = 1'b0;
            next_s.flags[FL_MASTER_BUS] = 1'b0;
            next_s.flags[FL_SLAVE_BUS]  = 1'b0;
        end

        // bus state tracking from the filtered pins and from bytes finished by the byte engine
        if (s.en_core && start_det) begin
            next_s.status[ST_BUS_STATE +: 2] = BS_BUSY;
        end
        if (s.en_core && stop_det) begin
            next_s.status[ST_BUS_STATE +: 2] = BS_IDLE;
        end
        if (xfer_done && s.en_core) begin
            next_s.last_rd                   = xfer_read;
            next_s.status[ST_CLK_HOLD]       = 1'b1;
            next_s.status[ST_BUS_STATE +: 2] = BS_OWNER;
            next_s.flags[xfer_read ? FL_SLAVE_BUS : FL_MASTER_BUS] = 1'b1;
        end

        // time-out counters only measure one unbroken low period
        if (!s.en_core || !s.ctrl_a[CA_LOW_TO_EN] || scl_hi) begin
            next_s.low_cnt = '0;
        end else if (s.low_cnt != LOW_LIM) begin
            next_s.low_cnt = s.low_cnt + 1'b1;
        end
        if (!s.en_core || s.ctrl_a[CA_IDLE_TO +: 2] == 2'h0 || scl_hi) begin
            next_s.idle_cnt = '0;
        end else if (s.idle_cnt != idle_lim) begin
            next_s.idle_cnt = s.idle_cnt + 1'b1;
        end
        if (idle_evt) begin
            next_s.status[ST_BUS_STATE +: 2] = BS_IDLE;
        end
        if (low_evt) begin
            next_s.status[ST_CLK_HOLD]  = 1'b0;
            next_s.flags[s.last_rd ? FL_SLAVE_BUS : FL_MASTER_BUS] = 1'b1;
            next_s.flags[FL_ERROR]      = 1'b1;
            next_s.status[ST_LOW_TO]    = 1'b1;
            next_s.status[ST_BUS_FAULT] = 1'b1;
            next_s.stp                  = STP_SETUP;
            next_s.stp_cnt              = '0;
        end

        // stop: scl low with sda low, then scl up, then sda up
        if (s.stp != STP_IDLE && !low_evt) begin
            next_s.stp_cnt = s.stp_cnt + 1'b1;
            if (s.stp_cnt == STOP_CNT_W'(STOP_HALF_CYC - 1)) begin
                next_s.stp_cnt = '0;
                case (s.stp)
                    STP_SETUP:  next_s.stp = STP_SCL_UP;
                    STP_SCL_UP: next_s.stp = STP_SDA_UP;
                    STP_SDA_UP: begin
                        next_s.stp                       = STP_IDLE;
                        next_s.status[ST_BUS_STATE +: 2] = BS_IDLE;
                    end
                    default:    next_s.stp = STP_IDLE;
                endcase
            end
        end

        if (s.sync_swrst && s.sync_cnt == 2'(SYNC_CYC - 1)) begin
            next_s     = '0;
            next_s.dbg = s.dbg;
            next_s.scl = pin_step(s.scl, scl_i);
            next_s.sda = pin_step(s.sda, sda_i);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign rdata     = s.rdata;
    assign err       = s.err;
    assign scl_o     = 1'b0;
    assign sda_o     = 1'b0;
    assign scl_drv_b = !(s.status[ST_CLK_HOLD] || s.stp == STP_SETUP);
    assign sda_drv_b = !(s.stp == STP_SETUP || s.stp == STP_SCL_UP);

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    wire err_cond_w = !aligned || s.sync_swrst || guard_lock;
    sequence en_written;
        req.wr && !err_cond_w && word == W_CA && m[CA_ENABLE] && !(m[CA_SWRST] && wd[CA_SWRST]);
    endsequence

    a_sync_delay: assert property (en_written |=> s.sync_en [*3] ##1 !s.sync_en)
        else $error("enable sync busy not three cycles");
    a_low_flags: assert property (low_evt && !s.sync_swrst
                                  |=> s.status[ST_LOW_TO] && s.status[ST_BUS_FAULT])
        else $error("low time-out status bits not set");
    a_low_release: assert property (low_evt && !s.sync_swrst |=> !s.status[ST_CLK_HOLD])
        else $error("clock hold kept after low time-out");
    a_low_stop: assert property (low_evt && !s.sync_swrst |=> s.stp == STP_SETUP ##1 !sda_drv_b)
        else $error("no stop after low time-out");
    a_low_bus_flag: assert property (low_evt && !s.last_rd && !s.sync_swrst
                                     |=> s.flags[FL_MASTER_BUS])
        else $error("master bus flag missing on low time-out");
    a_guard_block: assert property (req.wr && guard_lock && word == W_BR && !s.sync_swrst
                                    |=> $stable(s.bit_rate))
        else $error("guarded register written while locked");
    a_enable_prot: assert property (req.wr && en_prot && word == W_BR && !s.sync_swrst
                                    |=> $stable(s.bit_rate))
        else $error("protected register written while enabled");
    a_idle_state: assert property (idle_evt && !xfer_done && !s.sync_swrst
                                   |=> s.status[ST_BUS_STATE +: 2] == BS_IDLE)
        else $error("idle time-out did not force idle");
    a_low_restart: assert property (scl_hi |=> s.low_cnt == '0 && s.idle_cnt == '0)
        else $error("time-out counters not restarted");
    a_low_disabled: assert property (!s.ctrl_a[CA_LOW_TO_EN] |=> s.low_cnt == '0)
        else $error("low counter runs while disabled");

endmodule // i2m_master_timeout

// ===== testbench/i2m_bus_slave.sv
// two-wire slave model that can stretch scl, with pull-ups on both lines
`timescale 1ns/1ps
module i2m_bus_slave (
    input  wire logic scl_drv_b, // master pulls scl low
    input  wire logic sda_drv_b, // master pulls sda low
    input  wire logic stretch,   // slave holds scl low
    output logic      scl,       // resolved scl wire
    output logic      sda        // resolved sda wire
);
    // pull-ups: a released line reads high, never the last driven value
    assign scl = scl_drv_b & ~stretch;
    assign sda = sda_drv_b;
endmodule // i2m_bus_slave

// ===== testbench/tb_i2c_master_timeout_regs.sv
// self-checking bench of the two-wire master time-out block
`timescale 1ns/1ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin failures++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_i2c_master_timeout_regs import i2m_pkg::*;;
    localparam int LOWC = 50;
    logic        clk_sys;
    logic        rst_b;
    logic        guard_lock;
    logic        stretch;
    logic        xfer_done;
    logic        xfer_read;
    i2m_req_t    req;
    logic [31:0] rdata;
    logic        err;
    logic        scl_o;
    logic        scl_drv_b;
    logic        sda_o;
    logic        sda_drv_b;
    logic        scl;
    logic        sda;
    int          failures;
    int          checks_done;

    i2m_master_timeout #(.LOW_TO_CYCLES(LOWC), .IDLE_TO3_CYCLES(IDLE_TO3_CYC)) u_dut (
        .clk_sys(clk_sys), .rst_b(rst_b), .req(req), .guard_lock(guard_lock),
        .xfer_done(xfer_done), .xfer_read(xfer_read), .rdata(rdata), .err(err),
        .scl_i(scl), .scl_o(scl_o), .scl_drv_b(scl_drv_b),
        .sda_i(sda), .sda_o(sda_o), .sda_drv_b(sda_drv_b));
    i2m_bus_slave u_slv (.scl_drv_b(scl_drv_b), .sda_drv_b(sda_drv_b),
        .stretch(stretch), .scl(scl), .sda(sda));

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    // one access; answer is sampled at the falling edge after the taking edge
    task automatic acc(input logic w, input logic [5:0] a, input logic [1:0] s,
                       input logic [31:0] d);
        @(negedge clk_sys);
        req = '{wr: w, rd: !w, addr: a, size: s, wdata: d};
        @(negedge clk_sys);
        req = '0;
    endtask

    task automatic results;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic t_regs;
        acc(1'b0, OFS_CTRL_A, SZ_WORD, 32'h0);
        `CHK(rdata, 32'h00000000)
        acc(1'b1, 6'h0E, SZ_BYTE, 32'h000000A5);
        acc(1'b1, OFS_BIT_RATE, SZ_HALF, 32'h00001234);
        acc(1'b0, OFS_BIT_RATE, SZ_WORD, 32'h0);
        `CHK(rdata, 32'h00A51234)
        acc(1'b0, 6'h0E, SZ_BYTE, 32'h0);
        `CHK(rdata, 32'h000000A5)
        acc(1'b0, 6'h08, SZ_WORD, 32'h0);
        `CHK(err, 1'b1)
        guard_lock = 1'b1;
        acc(1'b1, OFS_BIT_RATE, SZ_WORD, 32'hFFFFFFFF);
        `CHK(err, 1'b1)
        guard_lock = 1'b0;
        acc(1'b0, OFS_BIT_RATE, SZ_WORD, 32'h0);
        `CHK(rdata, 32'h00A51234)
        $display("test regs done");
    endtask

    task automatic t_idle;
        acc(1'b1, OFS_CTRL_A, SZ_WORD, 32'h10000002);
        acc(1'b0, OFS_SYNC_PEND, SZ_WORD, 32'h0);
        `CHK(rdata[1], 1'b1)
        cyc(4);
        acc(1'b0, OFS_SYNC_PEND, SZ_WORD, 32'h0);
        `CHK(rdata[1], 1'b0)
        acc(1'b1, OFS_BIT_RATE, SZ_WORD, 32'h0);
        acc(1'b0, OFS_BIT_RATE, SZ_WORD, 32'h0);
        `CHK(rdata, 32'h00A51234)
        // 5 scl periods at 100 kHz are 2000 core cycles; margin covers the pin filter
        stretch = 1'b1;
        cyc(2010);
        acc(1'b0, OFS_BUS_STATUS, SZ_HALF, 32'h0);
        `CHK(rdata[5:4], BS_IDLE)
        `CHK(rdata[6], 1'b0)
        stretch = 1'b0;
        $display("test idle done");
    endtask

    task automatic t_low;
        int n;
        acc(1'b1, OFS_CTRL_A, SZ_WORD, 32'h0);
        cyc(5);
        acc(1'b1, OFS_CTRL_A, SZ_WORD, 32'h40000002);
        cyc(5);
        // a short high pulse must restart the count, so no time-out yet
        stretch = 1'b1;
        cyc(40);
        stretch = 1'b0;
        cyc(10);
        stretch = 1'b1;
        cyc(40);
        acc(1'b0, OFS_BUS_STATUS, SZ_HALF, 32'h0);
        `CHK(rdata[6], 1'b0)
        for (n = 0; n < 200 && sda_drv_b !== 1'b0; n++)
            @(negedge clk_sys);
        if (n == 200) begin
            failures++;
            results();
        end
        `CHK(n + 42 >= LOWC && n + 42 <= LOWC + 6, 1'b1)
        stretch = 1'b0;
        acc(1'b0, OFS_BUS_STATUS, SZ_HALF, 32'h0);
        `CHK(rdata[15:0] & 16'h0041, 16'h0041)
        acc(1'b0, OFS_IRQ_FLAGS, SZ_BYTE, 32'h0);
        `CHK(rdata[7:0], 8'h81)
        cyc(300);
        `CHK(scl_drv_b, 1'b1)
        `CHK(sda_drv_b, 1'b0)
        cyc(320);
        `CHK(sda_drv_b, 1'b1)
        acc(1'b0, OFS_BUS_STATUS, SZ_HALF, 32'h0);
        `CHK(rdata[5:4], BS_IDLE)
        $display("test low done");
    endtask

    // a read byte sets the hold; the low time-out must then flag the slave bus side
    task automatic t_hold;
        acc(1'b1, OFS_IRQ_FLAGS, SZ_WORD, 32'h07470083);
        xfer_read = 1'b1;
        xfer_done = 1'b1;
        cyc(1);
        xfer_done = 1'b0;
        acc(1'b0, OFS_IRQ_FLAGS, SZ_WORD, 32'h0);
        `CHK(rdata & 32'h00FF00FF, 32'h00A00002)
        cyc(55);
        acc(1'b0, OFS_IRQ_FLAGS, SZ_WORD, 32'h0);
        `CHK(rdata & 32'h00FF00FF, 32'h00610082)
        xfer_read = 1'b0;
        $display("test hold done");
    endtask

    // software reset, then a second hardware reset in mid-run
    task automatic t_swrst;
        acc(1'b1, OFS_DEBUG_CTRL, SZ_BYTE, 32'h1);
        acc(1'b1, OFS_CTRL_A, SZ_BYTE, 32'h1);
        acc(1'b1, OFS_BIT_RATE, SZ_WORD, 32'h0);
        `CHK(err, 1'b1)
        cyc(3);
        acc(1'b0, OFS_BIT_RATE, SZ_WORD, 32'h0);
        `CHK(rdata, 32'h0)
        acc(1'b0, OFS_DEBUG_CTRL, SZ_BYTE, 32'h0);
        `CHK(rdata, 32'h1)
        rst_b = 1'b0;
        cyc(5);
        rst_b = 1'b1;
        `CHK({scl_o, sda_o, scl_drv_b, sda_drv_b, err, rdata}, {5'h06, 32'h0})
        $display("test reset done");
    endtask

    initial begin
        rst_b = 1'b0;
        req = '0;
        guard_lock = 1'b0;
        stretch = 1'b0;
        xfer_done = 1'b0;
        xfer_read = 1'b0;
        failures = 0;
        checks_done = 0;
        cyc(5);
        rst_b = 1'b1;
        t_regs();
        t_idle();
        t_low();
        t_hold();
        t_swrst();
        results();
    end
endmodule // tb_i2c_master_timeout_regs
